// ==== sbs_host.sv ====
// bus controller model: commands, queries and serial polls
`timescale 1ns/10ps
module sbs_host
(
    // clock
    input  wire logic       clk_sys_i,
    // answers and service request
    input  wire logic [7:0] resp_data_i,
    input  wire logic       resp_valid_i,
    input  wire logic       srq_i,
    // command pulses and mask data
    output logic            stb_query_o,
    output logic            poll_o,
    output logic            clr_status_o,
    output logic            mask_wr_o,
    output logic [7:0]      mask_data_o,
    output logic            mask_query_o
);
    initial
    begin
        {stb_query_o, poll_o, clr_status_o, mask_wr_o, mask_query_o} = '0;
        mask_data_o = 8'h00;
    end
    // kind 0 stb query, 1 poll, 2 mask query, 3 mask write, 4 clear
    task automatic send(input int kind, input logic [7:0] data,
                        output logic [7:0] ans, output logic tmo);
        int n;
        @(posedge clk_sys_i);
        stb_query_o  <= (kind == 0);
        poll_o       <= (kind == 1);
        mask_query_o <= (kind == 2);
        mask_wr_o    <= (kind == 3);
        clr_status_o <= (kind == 4);
        mask_data_o  <= data;
        @(posedge clk_sys_i);
        {stb_query_o, poll_o, clr_status_o, mask_wr_o, mask_query_o} <= '0;
        // parameter no longer held once taken
        mask_data_o  <= ~data;
        ans = 8'h00;
        tmo = (kind < 3);
        // outputs settle just after the edge that takes the command
        #1;
        for (n = 0; n < 4 && tmo; n++)
        begin
            if (resp_valid_i)
            begin
                ans = resp_data_i;
                tmo = 1'b0;
            end
            else
            begin
                @(posedge clk_sys_i);
                #1;
            end
        end
    endtask : send
    // wait for a request line, then poll; caller tests bit 6
    task automatic service(output logic [7:0] ans, output logic tmo);
        int n;
        logic lost;
        for (n = 0; n < 8 && !srq_i; n++) @(posedge clk_sys_i);
        lost = !srq_i;
        send(1, 8'h00, ans, tmo);
        tmo = tmo | lost;
    endtask : service
endmodule : sbs_host

// ==== sbs_pkg.sv ====
// constants for the status byte and service request block
package sbs_pkg;
    // bit positions in the status byte
    localparam int unsigned EAV_BIT = 2;
    localparam int unsigned QSB_BIT = 3;
    localparam int unsigned MAV_BIT = 4;
    localparam int unsigned ESB_BIT = 5;
    localparam int unsigned RQS_BIT = 6;
    localparam int unsigned OSB_BIT = 7;
    // bits that carry a summary message
    localparam logic [7:0] SUM_MASK = 8'hbc;
    // reset values
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // answer source, in priority order
    typedef enum logic [1:0] {
        SBS_ANS_NONE = 2'b00,
        SBS_ANS_POLL = 2'b01,
        SBS_ANS_STB  = 2'b10,
        SBS_ANS_SRE  = 2'b11
    } sbs_ans_t;
endpackage : sbs_pkg

// ==== sbs_status_byte.sv ====
// status byte, service request mask and service request line
`timescale 1ns/10ps
// How it works
// - live byte bits 2,3,4,5,7 follow their summary inputs, never latched
// - a summary dropping to zero clears its status byte bit
// - status byte and service mask are each 8 bits wide
// - status query reports bit 6 as OR of summaries ANDed with mask
// - status query changes no bit of the status byte
// - serial poll reports request flag in bit 6, then clears it
// - poll clears request flag only; master summary follows summaries and mask
// - reset or clear-status clears the status byte; message available may stay
// - each summary gated by its mask bit, ORed into bit 6
// - mask write loads the mask; mask query returns it unchanged
// - mask clears at reset or on a write of zero
// - enabled summary rising sets request flag and raises service request
// - service request line asserted while request flag is set
// - after a poll, a new event of the same source requests again
// - message available bit follows output queue not empty
// - error available bit follows error queue not empty
module sbs_status_byte
    import sbs_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       reset_n_i,
    // summary messages
    input  wire logic       err_avail_i,
    input  wire logic       ques_sum_i,
    input  wire logic       msg_avail_i,
    input  wire logic       event_sum_i,
    input  wire logic       oper_sum_i,
    // new-event pulses, one per byte position
    input  wire logic [7:0] sum_event_i,
    // commands from the bus side, one-cycle pulses
    input  wire logic       stb_query_i,
    input  wire logic       poll_i,
    input  wire logic       clr_status_i,
    input  wire logic       mask_wr_i,
    input  wire logic [7:0] mask_data_i,
    input  wire logic       mask_query_i,
    // answers and service request
    output logic [7:0]      status_byte_o,
    output logic [7:0]      resp_data_o,
    output logic            resp_valid_o,
    output logic            srq_o
);

    logic [7:0] sum_w;
    logic [7:0] en_w;
    logic       mss_w;
    logic       req_w;

    logic [7:0] mask_q;
    logic [7:0] mask_d;
    logic       rqs_q;
    logic       rqs_d;
    logic [7:0] prev_en_q;
    logic [7:0] prev_en_d;
    logic [7:0] live_q;
    logic [7:0] live_d;
    logic [7:0] resp_q;
    logic [7:0] resp_d;
    logic       rvalid_q;
    logic       rvalid_d;
    sbs_ans_t   ans_w;

    // summary vector at byte positions
    always_comb
    begin
        sum_w          = 8'h00;
        sum_w[EAV_BIT] = err_avail_i;
        sum_w[QSB_BIT] = ques_sum_i;
        sum_w[MAV_BIT] = msg_avail_i;
        sum_w[ESB_BIT] = event_sum_i;
        sum_w[OSB_BIT] = oper_sum_i;
    end

    // gated summaries; mask_q never holds bit 6 or unused bits
    assign en_w  = sum_w & mask_q;
    assign mss_w = |en_w;
    // edge of an enabled summary, or a fresh event under it
    assign req_w = |(en_w & ~prev_en_q)
                 | |(sum_event_i & mask_q);

    // mask register
    // bit 6 and unused bits dropped on write, so they never gate bit 6
    always_comb
    begin
        mask_d = mask_q;
        if (mask_wr_i)
        begin
            mask_d = mask_data_i & SUM_MASK;
        end
    end

    // request flag; a new request wins over a poll or clear
    // enabling a mask bit over a set summary also counts as a rising edge
    always_comb
    begin
        rqs_d     = rqs_q;
        prev_en_d = en_w;
        if (req_w)
        begin
            rqs_d = 1'b1;
        end
        else if (poll_i || clr_status_i)
        begin
            rqs_d = 1'b0;
        end
    end

    // live byte: summaries pass through, only one flop of delay
    // clear blanks all but message available for one cycle only; summaries clear upstream
    always_comb
    begin
        live_d          = sum_w & SUM_MASK;
        live_d[RQS_BIT] = mss_w;
        if (clr_status_i)
        begin
            // message available may outlive a clear
            live_d          = BYTE_RST;
            live_d[MAV_BIT] = msg_avail_i;
        end
    end

    // answer select: poll first, then status query, then mask query
    // queries in one cycle: lower ones are dropped, so the host spaces them
    always_comb
    begin
        if (poll_i)
        begin
            ans_w = SBS_ANS_POLL;
        end
        else if (stb_query_i)
        begin
            ans_w = SBS_ANS_STB;
        end
        else if (mask_query_i)
        begin
            ans_w = SBS_ANS_SRE;
        end
        else
        begin
            ans_w = SBS_ANS_NONE;
        end
    end

    // answer data holds until the next answer; valid is a one-cycle pulse
    always_comb
    begin
        resp_d   = resp_q;
        rvalid_d = 1'b0;
        case (ans_w)
            SBS_ANS_POLL:
            begin
                resp_d          = sum_w & SUM_MASK;
                resp_d[RQS_BIT] = rqs_q;
                rvalid_d        = 1'b1;
            end
            SBS_ANS_STB:
            begin
                resp_d          = sum_w & SUM_MASK;
                resp_d[RQS_BIT] = mss_w;
                rvalid_d        = 1'b1;
            end
            SBS_ANS_SRE:
            begin
                resp_d   = mask_q;
                rvalid_d = 1'b1;
            end
            default:
            begin
                resp_d   = resp_q;
                rvalid_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            // power cycle: mask, flag and byte all start clear
            mask_q    <= MASK_RST;
            rqs_q     <= 1'b0;
            prev_en_q <= 8'h00;
            live_q    <= BYTE_RST;
            resp_q    <= 8'h00;
            rvalid_q  <= 1'b0;
        end
        else
        begin
            mask_q    <= mask_d;
            rqs_q     <= rqs_d;
            prev_en_q <= prev_en_d;
            live_q    <= live_d;
            resp_q    <= resp_d;
            rvalid_q  <= rvalid_d;
        end
    end

    assign status_byte_o = live_q;
    assign resp_data_o   = resp_q;
    assign resp_valid_o  = rvalid_q;
    assign srq_o         = rqs_q;

    // checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    chk_live_follow: assert property (
        !clr_status_i |=>
            (status_byte_o & SUM_MASK) == $past(sum_w & SUM_MASK))
        else $error("live byte does not follow summaries");

    chk_summary_drop: assert property (
        $fell(event_sum_i) |=> !status_byte_o[ESB_BIT])
        else $error("summary drop did not clear its bit");

    chk_stb_mss: assert property (
        stb_query_i && !poll_i |=>
            resp_valid_o && resp_data_o[RQS_BIT] == $past(mss_w))
        else $error("status query bit 6 not master summary");

    chk_stb_keep: assert property (
        stb_query_i && !poll_i && !clr_status_i && !req_w |=>
            rqs_q == $past(rqs_q)
            && (mask_q == $past(mask_q) || $past(mask_wr_i)))
        else $error("status query changed state");

    chk_poll_clear: assert property (
        poll_i && !req_w |=>
            !rqs_q && resp_valid_o
            && resp_data_o[RQS_BIT] == $past(rqs_q))
        else $error("poll answer or flag clear wrong");

    chk_poll_mss: assert property (
        poll_i && !clr_status_i |=>
            status_byte_o[RQS_BIT] == $past(mss_w))
        else $error("poll disturbed master summary");

    chk_clear_byte: assert property (
        clr_status_i |=>
            (status_byte_o & ~(8'h01 << MAV_BIT)) == BYTE_RST)
        else $error("clear left status bits set");

    chk_gate_or: assert property (
        !clr_status_i |=>
            status_byte_o[RQS_BIT] == |$past(sum_w & mask_q))
        else $error("bit 6 not gated OR of summaries");

    chk_mask_load: assert property (
        mask_wr_i |=> mask_q == $past(mask_data_i & SUM_MASK))
        else $error("mask not loaded from write");

    chk_mask_read: assert property (
        mask_query_i && !poll_i && !stb_query_i |=>
            resp_valid_o && resp_data_o == $past(mask_q)
            && ($past(mask_wr_i) || mask_q == $past(mask_q)))
        else $error("mask query wrong or destructive");

    chk_rise_srq: assert property (
        req_w |=> rqs_q && srq_o)
        else $error("enabled rise raised no request");

    chk_srq_hold: assert property (
        rqs_q && !poll_i && !clr_status_i |=> srq_o [*1])
        else $error("service request dropped without poll");

    chk_repeat_req: assert property (
        poll_i ##[1:4] |(sum_event_i & mask_q) |=> srq_o)
        else $error("fresh event after poll not requested");

    chk_unused_zero: assert property (
        ((mask_q | status_byte_o) & ~SUM_MASK & ~(8'h01 << RQS_BIT))
            == 8'h00 && !mask_q[RQS_BIT])
        else $error("unused bit set");

    chk_mav_follow: assert property (
        1'b1 |=> status_byte_o[MAV_BIT] == $past(msg_avail_i))
        else $error("message available bit wrong");

    chk_eav_follow: assert property (
        !clr_status_i |=> status_byte_o[EAV_BIT] == $past(err_avail_i))
        else $error("error available bit wrong");

    chk_mask_zero: assert property (
        mask_wr_i && mask_data_i == 8'h00 |=> mask_q == 8'h00)
        else $error("mask not cleared by zero write");

    chk_clear_srq: assert property (
        clr_status_i && !req_w |=> !srq_o)
        else $error("clear left service request set");

    cov_poll_req: cover property (rqs_q ##1 poll_i ##1 !rqs_q);
    cov_masked: cover property (|sum_w && mask_q == 8'h00);
    cov_rearm: cover property (poll_i ##[1:4] req_w);
    cov_clear: cover property (rqs_q ##1 clr_status_i);
    cov_mask_clear: cover property (mask_wr_i && mask_data_i == 8'h00);

endmodule : sbs_status_byte

// ==== tb_top.sv ====
// self-checking testbench for the status byte block
`timescale 1ns/10ps
module tb_top;
    import sbs_pkg::*;
    logic       clk_sys_i, reset_n_i, tmo;
    logic [7:0] sums, sum_event_i, mask_data_i, status_byte_o;
    logic [7:0] resp_data_o, ans;
    logic       stb_query_i, poll_i, clr_status_i, mask_wr_i;
    logic       mask_query_i, resp_valid_o, srq_o;
    int         error_cnt = 0;
    int         checked = 0;
    int         i;

    sbs_status_byte sbs_status_byte_i (.clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i), .err_avail_i(sums[EAV_BIT]),
        .ques_sum_i(sums[QSB_BIT]), .msg_avail_i(sums[MAV_BIT]),
        .event_sum_i(sums[ESB_BIT]), .oper_sum_i(sums[OSB_BIT]),
        .sum_event_i(sum_event_i), .stb_query_i(stb_query_i),
        .poll_i(poll_i), .clr_status_i(clr_status_i),
        .mask_wr_i(mask_wr_i), .mask_data_i(mask_data_i),
        .mask_query_i(mask_query_i), .status_byte_o(status_byte_o),
        .resp_data_o(resp_data_o), .resp_valid_o(resp_valid_o),
        .srq_o(srq_o));
    sbs_host sbs_host_i (.clk_sys_i(clk_sys_i), .resp_data_i(resp_data_o),
        .resp_valid_i(resp_valid_o), .srq_i(srq_o),
        .stb_query_o(stb_query_i), .poll_o(poll_i),
        .clr_status_o(clr_status_i), .mask_wr_o(mask_wr_i),
        .mask_data_o(mask_data_i), .mask_query_o(mask_query_i));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input string name, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic summarize();
        if (error_cnt == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task automatic cmd(input int kind, input logic [7:0] data);
        sbs_host_i.send(kind, data, ans, tmo);
        chk("answer timeout", {7'h00, tmo}, 8'h00);
        if (tmo)
            summarize();
    endtask : cmd
    // new summaries are sampled one edge later, byte settles after it
    task automatic set_sums(input logic [7:0] v);
        @(posedge clk_sys_i);
        sums <= v;
        @(posedge clk_sys_i);
        #1;
    endtask : set_sums

    initial
    begin
        reset_n_i = 1'b0;
        sums = 8'h00;
        sum_event_i = 8'h00;
        repeat (8) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        set_sums(8'h00);
        chk("byte after reset", status_byte_o, BYTE_RST);
        cmd(2, 8'h00);
        chk("mask after reset", ans, MASK_RST);
        for (i = 2; i < 8; i++)
            if (SUM_MASK[i])
            begin
                set_sums(8'h01 << i);
                chk("live bit", status_byte_o, 8'h01 << i);
                chk("masked srq", {7'h00, srq_o}, 8'h00);
                set_sums(8'h00);
                chk("bit dropped", status_byte_o, 8'h00);
            end
        cmd(3, 8'hff);
        cmd(2, 8'h00);
        chk("mask readback", ans, SUM_MASK);
        cmd(2, 8'h00);
        chk("mask kept", ans, SUM_MASK);
        cmd(3, 8'h20);
        set_sums(8'h20);
        chk("srq raised", {7'h00, srq_o}, 8'h01);
        cmd(0, 8'h00);
        chk("stb answer", ans, 8'h60);
        chk("stb keeps byte", status_byte_o, 8'h60);
        sbs_host_i.service(ans, tmo);
        chk("poll timeout", {7'h00, tmo}, 8'h00);
        chk("poll answer", ans, 8'h60);
        chk("srq after poll", {7'h00, srq_o}, 8'h00);
        chk("summary kept", status_byte_o, 8'h60);
        cmd(1, 8'h00);
        chk("second poll", ans, 8'h20);
        @(posedge clk_sys_i);
        sum_event_i <= 8'h20;
        @(posedge clk_sys_i);
        sum_event_i <= 8'h00;
        #1;
        chk("srq again", {7'h00, srq_o}, 8'h01);
        cmd(3, 8'h00);
        @(posedge clk_sys_i);
        #1;
        chk("mask zero byte", status_byte_o, 8'h20);
        cmd(2, 8'h00);
        chk("mask cleared", ans, 8'h00);
        set_sums(8'hb0);
        cmd(4, 8'h00);
        chk("clear byte", status_byte_o, 8'h10);
        chk("clear srq", {7'h00, srq_o}, 8'h00);
        // power cycle in mid-run with a mask loaded
        cmd(3, 8'h10);
        @(posedge clk_sys_i);
        reset_n_i <= 1'b0;
        #1;
        chk("srq in reset", {7'h00, srq_o}, 8'h00);
        chk("byte in reset", status_byte_o, BYTE_RST);
        @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        cmd(2, 8'h00);
        chk("mask after power cycle", ans, MASK_RST);
        chk("byte after power cycle", status_byte_o, 8'hb0);
        summarize();
    end
endmodule : tb_top
